// *** design/strap_pkg.sv ***
/*
  Shared constants and carrier types for the power-up strap latch.
  Assumes a single 50 MHz clock and a serial flash in mode-0 read.
*/
package strap_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // Timing
  localparam int CLK_PERIOD_NS = 20;
  localparam int SPI_HALF_NS = 100;
  // Least half period, so round up
  localparam int SPI_HALF_CYCLES =
    (SPI_HALF_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int DIV_W = 4;

  ////////////////////////////////////////////////////////////////////////////
  // Soft strap fetch
  localparam logic [7:0] FLASH_READ_CMD = 8'h03;
  localparam logic [23:0] SOFT_STRAP_ADDR = 24'h000100;
  localparam int SOFT_STRAP_BITS = 32;
  localparam int FRAME_BITS = 64;
  localparam logic [5:0] FRAME_LAST = 6'h3F;
  localparam logic [5:0] FRAME_RX_START = 6'h20;
  localparam logic [31:0] SOFT_STRAP_RESET = 32'h00000000;
  localparam int BLK_SEL_LSB = 0;

  ////////////////////////////////////////////////////////////////////////////
  // Swap block size and firmware address
  localparam int ADDR_W = 24;
  localparam logic [1:0] BLK_A16 = 2'h0;
  localparam logic [1:0] BLK_A17 = 2'h1;
  localparam logic [1:0] BLK_A18 = 2'h2;

  ////////////////////////////////////////////////////////////////////////////
  // Bridge configuration byte
  localparam logic [7:0] CFG_OFFSET = 8'hDC;
  localparam int CFG_SWAP_BIT = 4;
  localparam int CFG_DEST_BIT = 6;
  localparam logic [7:0] CFG_RESET = 8'h00;

  ////////////////////////////////////////////////////////////////////////////
  // Types
  typedef struct packed {
    logic boot_dest;
    logic reboot_suppress;
    logic swap;
  } core_straps_s;

  typedef struct packed {
    logic flash_share;
    logic oob_debug;
    logic ec_bus;
    logic cipher;
  } resume_straps_s;

  typedef struct packed {
    logic watchdog_reboot_en;
    logic cipher_en;
    logic ec_bus_espi;
    logic oob_debug_en;
    logic flash_share_periph;
    logic boot_firmware_destination;
    logic swap_active;
    logic [1:0] blk_sel;
  } strap_cfg_s;

  typedef enum logic [1:0] {
    FETCH_IDLE = 2'b00,
    FETCH_SHIFT = 2'b01,
    FETCH_DONE = 2'b10
  } fetch_state_e;

endpackage

// *** design/strap_capture.sv ***
/*
  One strap group: synchronises a sampling input and its strap pins,
  latches the pins on the sampling rise and holds them until it falls.
  Assumes the board keeps pins steady around the sampling edge.
*/
`timescale 1ns/1ps

module strap_capture #(
  parameter int W = 1
) (
  input wire logic clk,
  input wire logic nrst,
  input wire logic sample_in,
  input wire logic [W-1:0] pins_in,
  output logic [W-1:0] latched_q,
  output logic valid_q,
  output logic rise_q,
  output logic [W-1:0] pulldown_en
);

  logic sample_m_q;
  logic sample_s_q;
  logic [W-1:0] pins_m_q;
  logic [W-1:0] pins_s_q;

  ////////////////////////////////////////////////////////////////////////////
  // Two-stage synchronisers, first stage feeds only the second
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      sample_m_q <= 1'b0;
      sample_s_q <= 1'b0;
      pins_m_q <= '0;
      pins_s_q <= '0;
    end else begin
      sample_m_q <= sample_in;
      sample_s_q <= sample_m_q;
      pins_m_q <= pins_in;
      pins_s_q <= pins_m_q;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Capture and hold
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      latched_q <= '0;
      valid_q <= 1'b0;
      rise_q <= 1'b0;
    end else begin
      rise_q <= sample_s_q && !valid_q;
      if (sample_s_q && !valid_q) begin
        latched_q <= pins_s_q;
        valid_q <= 1'b1;
      end else if (!sample_s_q) begin
        latched_q <= '0;
        valid_q <= 1'b0;
      end
    end
  end

  // Pull-down released once the group has sampled
  assign pulldown_en = {W{!valid_q}};

  a_capture_value: assert property (@(posedge clk) disable iff (!nrst)
    $rose(valid_q) |-> latched_q == $past(pins_s_q))
    else $error("strap not captured from pins at sampling rise");

  a_hold_latched: assert property (@(posedge clk) disable iff (!nrst)
    valid_q && $past(valid_q) |-> $stable(latched_q))
    else $error("latched strap changed while sampling input high");

  a_pulldown_off: assert property (@(posedge clk) disable iff (!nrst)
    rise_q |-> pulldown_en == '0 && $past(pulldown_en) == {W{1'b1}})
    else $error("pull-down not released at sampling rise");

endmodule

// *** design/power_up_strap_latch.sv ***
/*
  Power-up strap latch: captures straps on power-good and resume-reset
  rises, fetches the soft strap word from serial flash, releases the
  management and host resets, and applies boot block swapping.
  Assumes pins and power-good inputs are asynchronous to clk.
*/
`timescale 1ns/1ps

module power_up_strap_latch (
  input wire logic clk,
  input wire logic nrst,
  input wire logic deep_sleep_power_good,
  input wire logic resume_reset_n,
  input wire logic core_power_good,
  input wire strap_pkg::core_straps_s core_pin_i,
  input wire strap_pkg::core_straps_s core_func_o,
  input wire strap_pkg::core_straps_s core_func_oe,
  output strap_pkg::core_straps_s core_pin_o,
  output strap_pkg::core_straps_s core_pin_oe,
  output strap_pkg::core_straps_s core_pulldown_en,
  input wire strap_pkg::resume_straps_s resume_pin_i,
  input wire strap_pkg::resume_straps_s resume_func_o,
  input wire strap_pkg::resume_straps_s resume_func_oe,
  output strap_pkg::resume_straps_s resume_pin_o,
  output strap_pkg::resume_straps_s resume_pin_oe,
  output strap_pkg::resume_straps_s resume_pulldown_en,
  output logic flash_cs_n,
  output logic flash_sck,
  output logic flash_mosi,
  input wire logic flash_miso,
  output logic mgmt_reset_n,
  output logic host_reset_n,
  input wire logic cfg_wr,
  input wire logic [7:0] cfg_addr,
  input wire logic [7:0] cfg_wdata,
  output logic [7:0] cfg_rdata,
  input wire logic [strap_pkg::ADDR_W-1:0] fw_addr_in,
  output logic [strap_pkg::ADDR_W-1:0] fw_addr_out,
  output strap_pkg::strap_cfg_s strap_cfg
);

  strap_pkg::core_straps_s core_lat;
  strap_pkg::resume_straps_s resume_lat;
  logic core_valid;
  logic core_rise;
  logic resume_valid;
  logic resume_rise;
  logic ds_m_q;
  logic ds_s_q;
  logic miso_m_q;
  logic miso_s_q;
  strap_pkg::fetch_state_e state_q;
  logic [strap_pkg::DIV_W-1:0] div_q;
  logic tick;
  logic sck_q;
  logic cs_n_q;
  logic [5:0] cnt_q;
  logic [31:0] tx_q;
  logic [31:0] rx_q;
  logic [31:0] soft_q;
  logic swap_q;
  logic dest_q;
  logic mgmt_q;
  logic host_q;
  logic cfg_hit;

  function automatic logic [strap_pkg::ADDR_W-1:0] swap_addr(
    input logic [strap_pkg::ADDR_W-1:0] a,
    input logic [1:0] sel
  );
    logic [strap_pkg::ADDR_W-1:0] r;
    r = a;
    case (sel)
      strap_pkg::BLK_A17: begin
        if (&a[strap_pkg::ADDR_W-1:18]) r[17] = !a[17];
      end
      strap_pkg::BLK_A18: begin
        if (&a[strap_pkg::ADDR_W-1:19]) r[18] = !a[18];
      end
      default: begin
        if (&a[strap_pkg::ADDR_W-1:17]) r[16] = !a[16];
      end
    endcase
    return r;
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Strap groups
  strap_capture #(.W(3)) u_core (
    .clk(clk),
    .nrst(nrst),
    .sample_in(core_power_good),
    .pins_in(core_pin_i),
    .latched_q(core_lat),
    .valid_q(core_valid),
    .rise_q(core_rise),
    .pulldown_en(core_pulldown_en)
  );

  // Resume reset is active low, so its deassertion is the sampling rise
  strap_capture #(.W(4)) u_resume (
    .clk(clk),
    .nrst(nrst),
    .sample_in(resume_reset_n),
    .pins_in(resume_pin_i),
    .latched_q(resume_lat),
    .valid_q(resume_valid),
    .rise_q(resume_rise),
    .pulldown_en(resume_pulldown_en)
  );

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      ds_m_q <= 1'b0;
      ds_s_q <= 1'b0;
      miso_m_q <= 1'b0;
      miso_s_q <= 1'b0;
    end else begin
      ds_m_q <= deep_sleep_power_good;
      ds_s_q <= ds_m_q;
      miso_m_q <= flash_miso;
      miso_s_q <= miso_m_q;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Pin hand-back: strap pins stay undriven until their group sampled
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      core_pin_o <= '0;
      core_pin_oe <= '0;
      resume_pin_o <= '0;
      resume_pin_oe <= '0;
    end else begin
      core_pin_o <= core_func_o;
      resume_pin_o <= resume_func_o;
      core_pin_oe <= core_valid ? core_func_oe : '0;
      resume_pin_oe <= resume_valid ? resume_func_oe : '0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Soft strap fetch over serial flash, mode 0
  assign tick = div_q == strap_pkg::DIV_W'(strap_pkg::SPI_HALF_CYCLES - 1);

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      div_q <= '0;
    end else if (state_q != strap_pkg::FETCH_SHIFT || tick) begin
      div_q <= '0;
    end else begin
      div_q <= div_q + 1'b1;
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      state_q <= strap_pkg::FETCH_IDLE;
      sck_q <= 1'b0;
      cs_n_q <= 1'b1;
      cnt_q <= '0;
      tx_q <= '0;
      rx_q <= '0;
      soft_q <= strap_pkg::SOFT_STRAP_RESET;
    end else if (!resume_valid || !ds_s_q) begin
      // Losing resume power aborts and forgets the word
      state_q <= strap_pkg::FETCH_IDLE;
      sck_q <= 1'b0;
      cs_n_q <= 1'b1;
      soft_q <= strap_pkg::SOFT_STRAP_RESET;
    end else begin
      unique case (state_q)
        strap_pkg::FETCH_IDLE: begin
          state_q <= strap_pkg::FETCH_SHIFT;
          cs_n_q <= 1'b0;
          cnt_q <= '0;
          tx_q <= {strap_pkg::FLASH_READ_CMD, strap_pkg::SOFT_STRAP_ADDR};
        end
        strap_pkg::FETCH_SHIFT: begin
          if (tick && !sck_q) begin
            sck_q <= 1'b1;
            if (cnt_q >= strap_pkg::FRAME_RX_START) begin
              rx_q <= {rx_q[30:0], miso_s_q};
            end
          end else if (tick) begin
            sck_q <= 1'b0;
            tx_q <= {tx_q[30:0], 1'b0};
            cnt_q <= cnt_q + 1'b1;
            if (cnt_q == strap_pkg::FRAME_LAST) begin
              state_q <= strap_pkg::FETCH_DONE;
              cs_n_q <= 1'b1;
              soft_q <= rx_q;
            end
          end
        end
        strap_pkg::FETCH_DONE: begin
          state_q <= strap_pkg::FETCH_DONE;
        end
      endcase
    end
  end

  assign flash_cs_n = cs_n_q;
  assign flash_sck = sck_q;
  assign flash_mosi = tx_q[31];

  ////////////////////////////////////////////////////////////////////////////
  // Reset release waits on the fetched soft straps
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      mgmt_q <= 1'b0;
      host_q <= 1'b0;
    end else begin
      // Deep sleep loss drops both resets in the same cycle as the abort
      mgmt_q <= resume_valid && ds_s_q
        && state_q == strap_pkg::FETCH_DONE;
      host_q <= mgmt_q && core_valid && resume_valid && ds_s_q;
    end
  end

  assign mgmt_reset_n = mgmt_q;
  assign host_reset_n = host_q;

  ////////////////////////////////////////////////////////////////////////////
  // Swap and boot destination control bits
  assign cfg_hit = cfg_addr == strap_pkg::CFG_OFFSET;

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      swap_q <= 1'b0;
    end else if (!core_valid) begin
      swap_q <= 1'b0;
    end else if (core_rise && core_lat.swap) begin
      swap_q <= 1'b1;
    end else if (cfg_wr && cfg_hit && cfg_wdata[strap_pkg::CFG_SWAP_BIT]) begin
      // Writes may set but never clear
      swap_q <= 1'b1;
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      dest_q <= 1'b0;
    end else if (!core_valid) begin
      dest_q <= 1'b0;
    end else if (core_rise) begin
      dest_q <= core_lat.boot_dest;
    end else if (cfg_wr && cfg_hit) begin
      dest_q <= cfg_wdata[strap_pkg::CFG_DEST_BIT];
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      cfg_rdata <= strap_pkg::CFG_RESET;
    end else begin
      cfg_rdata <= strap_pkg::CFG_RESET;
      if (cfg_hit) begin
        cfg_rdata[strap_pkg::CFG_SWAP_BIT] <= swap_q;
        cfg_rdata[strap_pkg::CFG_DEST_BIT] <= dest_q;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Firmware address path, one cycle of latency
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      fw_addr_out <= '0;
    end else if (swap_q) begin
      fw_addr_out <= swap_addr(fw_addr_in,
        soft_q[strap_pkg::BLK_SEL_LSB +: 2]);
    end else begin
      fw_addr_out <= fw_addr_in;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Configuration outputs
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      strap_cfg <= '0;
    end else begin
      strap_cfg.watchdog_reboot_en <= !core_lat.reboot_suppress;
      strap_cfg.cipher_en <= resume_lat.cipher;
      strap_cfg.ec_bus_espi <= resume_lat.ec_bus;
      strap_cfg.oob_debug_en <= resume_lat.oob_debug;
      strap_cfg.flash_share_periph <= resume_lat.flash_share;
      strap_cfg.boot_firmware_destination <= dest_q;
      strap_cfg.swap_active <= swap_q;
      strap_cfg.blk_sel <= soft_q[strap_pkg::BLK_SEL_LSB +: 2];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Checks
  sequence s_fetch_done;
    state_q == strap_pkg::FETCH_DONE;
  endsequence

  a_reset_after_fetch: assert property (@(posedge clk) disable iff (!nrst)
    mgmt_q |-> s_fetch_done)
    else $error("management reset released before soft strap fetch");

  a_host_order: assert property (@(posedge clk) disable iff (!nrst)
    host_q |-> mgmt_q && $past(mgmt_q))
    else $error("host reset released ahead of management reset");

  a_swap_strap: assert property (@(posedge clk) disable iff (!nrst)
    core_rise && core_lat.swap |=> swap_q [*2])
    else $error("swap strap of one did not enable swapping");

  a_swap_sticky: assert property (@(posedge clk) disable iff (!nrst)
    swap_q && core_valid ##1 core_valid |-> swap_q)
    else $error("swap bit cleared without reboot");

  a_addr_swap: assert property (@(posedge clk) disable iff (!nrst)
    swap_q && soft_q[1:0] == strap_pkg::BLK_A16 && &fw_addr_in[23:17]
    |=> fw_addr_out[16] != $past(fw_addr_in[16]))
    else $error("A16 not inverted in upper blocks while swapping");

  a_addr_plain: assert property (@(posedge clk) disable iff (!nrst)
    !swap_q |=> fw_addr_out == $past(fw_addr_in))
    else $error("address altered while swapping disabled");

  a_cfg_reflect: assert property (@(posedge clk) disable iff (!nrst)
    cfg_hit |=> cfg_rdata[4] == $past(swap_q))
    else $error("swap bit not reflected at DCh bit4");

  a_watchdog_map: assert property (@(posedge clk) disable iff (!nrst)
    core_rise ##2 1 |-> strap_cfg.watchdog_reboot_en
      == !$past(core_lat.reboot_suppress, 2))
    else $error("watchdog reboot enable wrong for latched strap");

  a_resume_map: assert property (@(posedge clk) disable iff (!nrst)
    resume_rise |=> strap_cfg.ec_bus_espi == $past(resume_lat.ec_bus)
      && strap_cfg.cipher_en == $past(resume_lat.cipher))
    else $error("resume strap not mapped to configuration output");

endmodule

// *** dv/soft_strap_flash.sv ***
/*
  Behavioural serial flash holding the soft strap word, mode-0 read.
  Assumes the strap latch is the only master on cs_n, sck and mosi.
*/
`timescale 1ns/1ps

module soft_strap_flash (
  input wire logic cs_n,
  input wire logic sck,
  input wire logic mosi,
  input wire logic [31:0] soft_word,
  output logic miso,
  output logic [31:0] hdr,
  output int nbits
);
  initial begin
    miso = 1'b0;
    hdr = 32'h0;
    nbits = 0;
  end

  always @(negedge cs_n) begin
    nbits = 0;
    hdr = 32'h0;
  end

  // Command and address captured on sck rise
  always @(posedge sck) begin
    if (!cs_n) begin
      if (nbits < 32) hdr = {hdr[30:0], mosi};
      nbits = nbits + 1;
    end
  end

  // Data out on sck fall; toggles while no data is due
  always @(negedge sck) begin
    if (!cs_n && nbits >= 32 && nbits < 64) begin
      miso = soft_word[63-nbits];
    end else if (!cs_n) begin
      miso = ~miso;
    end
  end

  // Released line has no pull, so never holds the last bit
  always @(posedge cs_n) miso = ~miso;
endmodule

// *** dv/tb_top.sv ***
/*
  Self-checking bench for the power-up strap latch.
  Assumes the soft strap flash model and the design package.
*/
`timescale 1ns/1ps

`define CHK(g, e) begin compares++; if ((g) !== (e)) begin error_cnt++; \
  $display("ERROR t=%0t got=%0h exp=%0h", $time, (g), (e)); end end

module tb_top;
  typedef struct {
    strap_pkg::resume_straps_s r;
    strap_pkg::core_straps_s c;
    logic [1:0] blk;
    logic [23:0] hi;
  } row_s;

  logic clk = 1'b0;
  logic nrst = 1'b0;
  logic ds_good = 1'b0;
  logic rsm_n = 1'b0;
  logic core_good = 1'b0;
  strap_pkg::core_straps_s c_pin = 3'h0;
  strap_pkg::core_straps_s c_fo = 3'h5;
  strap_pkg::core_straps_s c_foe = 3'h7;
  strap_pkg::core_straps_s c_po, c_poe, c_pd;
  strap_pkg::resume_straps_s r_pin = 4'h0;
  strap_pkg::resume_straps_s r_fo = 4'hA;
  strap_pkg::resume_straps_s r_foe = 4'hF;
  strap_pkg::resume_straps_s r_po, r_poe, r_pd;
  logic cs_n, sck, mosi, miso, mgmt_n, host_n;
  logic cfg_wr = 1'b0;
  logic [7:0] cfg_addr = 8'hDC;
  logic [7:0] cfg_wdata = 8'h00;
  logic [7:0] cfg_rdata;
  logic [23:0] fa_in = 24'h000000;
  logic [23:0] fa_out;
  strap_pkg::strap_cfg_s cfg;
  logic [31:0] word = 32'h0;
  // Reserved straps are board pull-ups with no input on this block
  logic reserved_pin = 1'b1;
  localparam logic [31:0] HDR_EXP =
    {strap_pkg::FLASH_READ_CMD, strap_pkg::SOFT_STRAP_ADDR};
  logic [31:0] hdr;
  int nbits;
  int error_cnt = 0;
  int compares = 0;
  int cycles = 0;
  int k;
  // Inputs beside the high address they should give
  row_s rows [5] = '{
    '{4'h0, 3'h0, 2'h0, 24'hFF0000},
    '{4'hF, 3'h7, 2'h1, 24'hFD0000},
    '{4'h4, 3'h1, 2'h2, 24'hFB0000},
    '{4'h3, 3'h5, 2'h3, 24'hFE0000},
    '{4'hA, 3'h1, 2'h0, 24'hFE0000}};

  power_up_strap_latch power_up_strap_latch_inst (
    .clk(clk), .nrst(nrst), .deep_sleep_power_good(ds_good),
    .resume_reset_n(rsm_n), .core_power_good(core_good),
    .core_pin_i(c_pin), .core_func_o(c_fo), .core_func_oe(c_foe),
    .core_pin_o(c_po), .core_pin_oe(c_poe), .core_pulldown_en(c_pd),
    .resume_pin_i(r_pin), .resume_func_o(r_fo), .resume_func_oe(r_foe),
    .resume_pin_o(r_po), .resume_pin_oe(r_poe),
    .resume_pulldown_en(r_pd), .flash_cs_n(cs_n), .flash_sck(sck),
    .flash_mosi(mosi), .flash_miso(miso), .mgmt_reset_n(mgmt_n),
    .host_reset_n(host_n), .cfg_wr(cfg_wr), .cfg_addr(cfg_addr),
    .cfg_wdata(cfg_wdata), .cfg_rdata(cfg_rdata), .fw_addr_in(fa_in),
    .fw_addr_out(fa_out), .strap_cfg(cfg));

  soft_strap_flash soft_strap_flash_inst (
    .cs_n(cs_n), .sck(sck), .mosi(mosi), .soft_word(word),
    .miso(miso), .hdr(hdr), .nbits(nbits));

  always #10 clk = ~clk;

  ////////////////////////////////////////////////////////////////////////////
  task tick(input int n);
    repeat (n) @(posedge clk);
  endtask

  task cfg_write(input logic [7:0] d);
    @(posedge clk);
    cfg_wr <= 1'b1;
    cfg_wdata <= d;
    @(posedge clk);
    cfg_wr <= 1'b0;
    tick(2);
    #1;
  endtask

  task finish_test;
    $display("compares=%0d error_cnt=%0d", compares, error_cnt);
    if (error_cnt == 0 && compares > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  // Whole run is about 3400 cycles
  always @(posedge clk) begin
    cycles++;
    if (cycles == 10000) begin
      error_cnt++;
      finish_test();
    end
  end

  initial begin
    tick(2);
    #1;
    `CHK(cs_n, 1'b1)
    `CHK(mgmt_n, 1'b0)
    `CHK(c_pd, 3'h7)
    `CHK(r_pd, 4'hF)
    @(posedge clk);
    nrst <= 1'b1;
    ds_good <= 1'b1;
    for (int i = 0; i < 5; i++) begin
      @(posedge clk);
      core_good <= 1'b0;
      rsm_n <= 1'b0;
      r_pin <= rows[i].r;
      c_pin <= rows[i].c;
      word <= {30'h2AAAAAAA, rows[i].blk};
      tick(6);
      #1;
      `CHK(r_pd, 4'hF)
      `CHK(r_poe, 4'h0)
      @(posedge clk);
      rsm_n <= 1'b1;
      for (k = 0; k < 1000 && mgmt_n !== 1'b1; k++) @(posedge clk);
      #1;
      `CHK(mgmt_n, 1'b1)
      `CHK(cs_n, 1'b1)
      `CHK(hdr, HDR_EXP)
      `CHK(nbits, 64)
      `CHK(cfg.blk_sel, rows[i].blk)
      `CHK(host_n, 1'b0)
      `CHK(r_pd, 4'h0)
      `CHK(r_poe, r_foe)
      `CHK(r_po, r_fo)
      `CHK(cfg.cipher_en, rows[i].r.cipher)
      `CHK(cfg.ec_bus_espi, rows[i].r.ec_bus)
      `CHK(cfg.oob_debug_en, rows[i].r.oob_debug)
      `CHK(cfg.flash_share_periph, rows[i].r.flash_share)
      @(posedge clk);
      core_good <= 1'b1;
      fa_in <= 24'hFF0000;
      tick(8);
      #1;
      `CHK(host_n, 1'b1)
      `CHK(c_pd, 3'h0)
      `CHK(c_poe, c_foe)
      `CHK(c_po, c_fo)
      `CHK(cfg.watchdog_reboot_en, ~rows[i].c.reboot_suppress)
      `CHK(cfg.swap_active, rows[i].c.swap)
      `CHK(cfg.boot_firmware_destination, rows[i].c.boot_dest)
      `CHK(cfg_rdata, {1'b0, rows[i].c[2], 1'b0, rows[i].c[0], 4'h0})
      `CHK(fa_out, rows[i].hi)
      @(posedge clk);
      fa_in <= 24'h7F0000;
      c_pin <= ~rows[i].c;
      r_pin <= ~rows[i].r;
      tick(6);
      #1;
      `CHK(fa_out, 24'h7F0000)
      `CHK(cfg.swap_active, rows[i].c.swap)
      `CHK(cfg.cipher_en, rows[i].r.cipher)
      `CHK(cfg.ec_bus_espi, rows[i].r.ec_bus)
    end
    // Last row left swap on and destination clear
    cfg_write(8'h40);
    `CHK(cfg_rdata, 8'h50)
    `CHK(cfg.boot_firmware_destination, 1'b1)
    cfg_write(8'h00);
    `CHK(cfg_rdata, 8'h10)
    `CHK(cfg.swap_active, 1'b1)
    @(posedge clk);
    cfg_addr <= 8'hDD;
    tick(2);
    #1;
    `CHK(cfg_rdata, 8'h00)
    @(posedge clk);
    cfg_addr <= 8'hDC;
    core_good <= 1'b0;
    tick(6);
    #1;
    `CHK(cfg_rdata, 8'h00)
    `CHK(cfg.swap_active, 1'b0)
    @(posedge clk);
    ds_good <= 1'b0;
    for (k = 0; k < 20 && mgmt_n !== 1'b0; k++) @(posedge clk);
    #1;
    `CHK(mgmt_n, 1'b0)
    // Mid-run reset forgets the group, release re-samples held pins
    @(posedge clk);
    nrst <= 1'b0;
    tick(1);
    #1;
    `CHK(r_pd, 4'hF)
    `CHK(r_poe, 4'h0)
    @(posedge clk);
    nrst <= 1'b1;
    tick(5);
    #1;
    `CHK(r_pd, 4'h0)
    `CHK(cfg.cipher_en, ~rows[4].r.cipher)
    finish_test();
  end
endmodule
